// >>> design/irq_ctrl_map.svh
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

// How it works
// - timer-2 overflow requests vector 008 when its flag, mask bit 6, global flag set
// - capture event sets capture flag; vector 00A requested with mask bit 5, global flag
// - timer-1 compare A requests vector 00C with its flag, mask bit 4, global flag
// - timer-1 compare B requests vector 00E with its flag, mask bit 3, global flag
// - timer-1 overflow requests vector 010 with its flag, mask bit 2, global flag
// - timer-0 overflow requests vector 012 with its flag, mask bit 0, global flag
// - timer-2 count matching its compare value sets flag bit 7
// - taking a vector clears its flag; writing one to a flag clears it
// - timer-2 up/down pwm reversal at bottom sets the timer-2 overflow flag
// - timer-1 up/down pwm reversal at bottom sets the timer-1 overflow flag
// - capture flag bit 5 sets together with the capture copy
// - flag bit 1 and mask bit 1 always read zero
// - pin activity is seen even while the pin is driven as an output
// - enabled level sensing keeps requesting while the pin stays low
// - sleep instruction sleeps only while the sleep-arm bit 6 is set
// - sleep field bits 5:4 selects idle, noise reduction, power-down, power save
// - pin-one sense bits 3:2: low level, any change, falling, rising
// - pin-zero sense bits 1:0: low level, any change, falling, rising
// - pins are sampled on the clock before edge detection
// - external interrupt one active only with global flag and pin-one mask bit
// - external zero vectors to 002, external one to 004
// - an external flag is held clear while its pin uses level sensing
// - taking an interrupt clears the global flag, interrupt return sets it
// - flags stay set while disabled and are served once enabled

// register indices, byte address is four times the index
`define IDX_MCU_CONTROL   6'h35
`define IDX_TIMER_FLAGS   6'h38
`define IDX_TIMER_MASK    6'h39
`define IDX_EXT_FLAGS     6'h3a
`define IDX_GENERAL_MASK  6'h3b
`define IDX_STATUS_WORD   6'h3c

// field positions
`define BIT_SLEEP_ARM     6
`define BIT_PIN_ONE_EN    7
`define BIT_PIN_ZERO_EN   6
`define BIT_GLOBAL_IRQ    7

// writable bit masks
`define MCU_CONTROL_WMASK 8'h7f
`define TIMER_MASK_WMASK  8'hfd
`define TIMER_FLAG_WMASK  8'hfd
`define EXT_MASK_WMASK    8'hc0

// reset values
`define MCU_CONTROL_RST   8'h00
`define TIMER_MASK_RST    8'h00
`define TIMER_FLAGS_RST   8'h00
`define EXT_REG_RST       8'h00

// number of request sources, priority index 0 is the lowest vector
`define NUM_SOURCES       9

`endif

// >>> design/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

   // encodings follow the two-bit control fields in declaration order
   typedef enum logic [1:0] {
      SENSE_LOW,
      SENSE_ANY,
      SENSE_FALL,
      SENSE_RISE
   } sense_mode_t;

   typedef enum logic [1:0] {
      SLEEP_IDLE,
      SLEEP_NOISE_REDUCE,
      SLEEP_POWER_DOWN,
      SLEEP_POWER_SAVE
   } sleep_mode_t;

endpackage : irq_ctrl_pkg

// >>> design/pin_sense.sv
`timescale 1ns/100ps
module pin_sense
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        arst_n_i,
   // pad level and sense selection
   input  wire logic        pin_i,
   input  wire sense_mode_t sense_i,
   // detection results
   output logic             event_o,
   output logic             low_o
);

   logic sync_a_reg;
   logic sync_b_reg;
   logic prev_reg;

   // sample the pad on the clock; the second stage and its delayed copy are looked at
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_a_reg <= 1'b1;
         sync_b_reg <= 1'b1;
         prev_reg   <= 1'b1;
      end else begin
         sync_a_reg <= pin_i;
         sync_b_reg <= sync_a_reg;
         prev_reg   <= sync_b_reg;
      end
   end

   // edge selection on the sampled level; pulses under one period may be missed
   always_comb begin
      event_o = 1'b0;
      case (sense_i)
         SENSE_ANY:  event_o = sync_b_reg ^ prev_reg;
         SENSE_FALL: event_o = prev_reg & ~sync_b_reg;
         SENSE_RISE: event_o = ~prev_reg & sync_b_reg;
         default:    event_o = 1'b0;
      endcase
   end

   assign low_o = ~sync_b_reg;

endmodule : pin_sense

// >>> design/timer_pin_irq_ctrl.sv
`timescale 1ns/100ps
`include "irq_ctrl_map.svh"
module timer_pin_irq_ctrl
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        arst_n_i,
   // wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // timer inputs; event and reversal inputs are one-cycle pulses
   input  wire logic [7:0]  t2_count_i,
   input  wire logic [7:0]  t2_compare_value_i,
   input  wire logic        t2_overflow_evt_i,
   input  wire logic        t2_updown_mode_i,
   input  wire logic        t2_reverse_i,
   input  wire logic        capture_evt_i,
   input  wire logic        t1_compare_a_evt_i,
   input  wire logic        t1_compare_b_evt_i,
   input  wire logic        t1_overflow_evt_i,
   input  wire logic        t1_updown_mode_i,
   input  wire logic        t1_reverse_i,
   input  wire logic        t0_overflow_evt_i,
   // external interrupt pad levels
   input  wire logic        ext_irq_pin_zero_i,
   input  wire logic        ext_irq_pin_one_i,
   // processor core
   input  wire logic        irq_take_i,
   input  wire logic        interrupt_return_op_i,
   input  wire logic        sleep_op_i,
   output logic             irq_req_o,
   output logic [7:0]       irq_vector_o,
   output logic             sleep_o,
   output sleep_mode_t      sleep_mode_o
);

   // register state
   logic [7:0] mcu_control_reg;
   logic [7:0] timer_interrupt_mask_reg;
   logic [7:0] timer_interrupt_flags_reg;
   logic [7:0] general_interrupt_mask_reg;
   logic [7:0] ext_flags_reg;
   logic       global_irq_reg;
   logic       t2_match_prev_reg;
   logic [3:0] irq_idx_reg;

   // decoded bus access
   logic [5:0] reg_idx;
   logic       bus_req;
   logic       wr_fire;
   logic [7:0] wr_byte;
   logic [7:0] rd_byte;

   // event and request terms
   logic [7:0] timer_set;
   logic [7:0] timer_take_clr;
   logic [7:0] timer_next;
   logic [7:0] ext_set;
   logic [7:0] ext_take_clr;
   logic [7:0] ext_next;
   logic [`NUM_SOURCES-1:0] pending;
   logic [3:0] best_idx;
   logic       any_pending;
   logic       take_fire;
   logic       t2_match;
   logic       ext0_event;
   logic       ext0_low;
   logic       ext1_event;
   logic       ext1_low;
   logic       ext0_level;
   logic       ext1_level;
   sense_mode_t pin_zero_sense;
   sense_mode_t pin_one_sense;

   assign reg_idx = wb_adr_i[7:2];
   assign bus_req = wb_cyc_i & wb_stb_i;
   // a write lands at the edge where the master sees ack high
   assign wr_fire = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wr_byte = wb_dat_i[7:0];
   assign take_fire = irq_take_i & irq_req_o;

   // control fields of the mcu control register
   assign pin_zero_sense = sense_mode_t'(mcu_control_reg[1:0]);
   assign pin_one_sense  = sense_mode_t'(mcu_control_reg[3:2]);
   assign ext0_level     = (pin_zero_sense == SENSE_LOW);
   assign ext1_level     = (pin_one_sense == SENSE_LOW);

   // pad inputs are read straight from the pad, so a pin driven as output still triggers
   pin_sense u_sense_zero (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .pin_i     (ext_irq_pin_zero_i),
      .sense_i   (pin_zero_sense),
      .event_o   (ext0_event),
      .low_o     (ext0_low)
   );

   pin_sense u_sense_one (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .pin_i     (ext_irq_pin_one_i),
      .sense_i   (pin_one_sense),
      .event_o   (ext1_event),
      .low_o     (ext1_low)
   );

   // compare match counts once per entry into equality, so a cleared flag stays clear
   assign t2_match = (t2_count_i == t2_compare_value_i);

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         t2_match_prev_reg <= 1'b0;
      end else begin
         t2_match_prev_reg <= t2_match;
      end
   end

   // timer flag set sources
   always_comb begin
      timer_set    = 8'h00;
      timer_set[7] = t2_match & ~t2_match_prev_reg;
      timer_set[6] = t2_overflow_evt_i | (t2_updown_mode_i & t2_reverse_i);
      timer_set[5] = capture_evt_i;
      timer_set[4] = t1_compare_a_evt_i;
      timer_set[3] = t1_compare_b_evt_i;
      timer_set[2] = t1_overflow_evt_i | (t1_updown_mode_i & t1_reverse_i);
      timer_set[0] = t0_overflow_evt_i;
   end

   // hardware clear of the flag whose vector the core takes
   always_comb begin
      timer_take_clr = 8'h00;
      ext_take_clr   = 8'h00;
      if (take_fire) begin
         case (irq_idx_reg)
            4'd0:    ext_take_clr[`BIT_PIN_ZERO_EN] = 1'b1;
            4'd1:    ext_take_clr[`BIT_PIN_ONE_EN]  = 1'b1;
            4'd2:    timer_take_clr[7] = 1'b1;
            4'd3:    timer_take_clr[6] = 1'b1;
            4'd4:    timer_take_clr[5] = 1'b1;
            4'd5:    timer_take_clr[4] = 1'b1;
            4'd6:    timer_take_clr[3] = 1'b1;
            4'd7:    timer_take_clr[2] = 1'b1;
            4'd8:    timer_take_clr[0] = 1'b1;
            default: timer_take_clr = 8'h00;
         endcase
      end
   end

   // flags: set beats any clear arriving in the same cycle
   always_comb begin
      timer_next = timer_interrupt_flags_reg & ~timer_take_clr;
      if (wr_fire && reg_idx == `IDX_TIMER_FLAGS) begin
         timer_next = timer_next & ~(wr_byte & `TIMER_FLAG_WMASK);
      end
      timer_next = (timer_next | timer_set) & `TIMER_FLAG_WMASK;
   end

   always_comb begin
      ext_set = 8'h00;
      ext_set[`BIT_PIN_ZERO_EN] = ext0_event;
      ext_set[`BIT_PIN_ONE_EN]  = ext1_event;
      ext_next = ext_flags_reg & ~ext_take_clr;
      if (wr_fire && reg_idx == `IDX_EXT_FLAGS) begin
         ext_next = ext_next & ~(wr_byte & `EXT_MASK_WMASK);
      end
      ext_next = (ext_next | ext_set) & `EXT_MASK_WMASK;
      // level sensing has no memory, the flag is held clear
      if (ext0_level) begin
         ext_next[`BIT_PIN_ZERO_EN] = 1'b0;
      end
      if (ext1_level) begin
         ext_next[`BIT_PIN_ONE_EN] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer_interrupt_flags_reg <= `TIMER_FLAGS_RST;
         ext_flags_reg             <= `EXT_REG_RST;
      end else begin
         timer_interrupt_flags_reg <= timer_next;
         ext_flags_reg             <= ext_next;
      end
   end

   // software-written control and mask registers
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mcu_control_reg            <= `MCU_CONTROL_RST;
         timer_interrupt_mask_reg   <= `TIMER_MASK_RST;
         general_interrupt_mask_reg <= `EXT_REG_RST;
      end else if (wr_fire) begin
         if (reg_idx == `IDX_MCU_CONTROL) begin
            mcu_control_reg <= wr_byte & `MCU_CONTROL_WMASK;
         end else if (reg_idx == `IDX_TIMER_MASK) begin
            timer_interrupt_mask_reg <= wr_byte & `TIMER_MASK_WMASK;
         end else if (reg_idx == `IDX_GENERAL_MASK) begin
            general_interrupt_mask_reg <= wr_byte & `EXT_MASK_WMASK;
         end
      end
   end

   // global flag: taking clears it, interrupt return sets it, software may write it
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         global_irq_reg <= 1'b0;
      end else if (take_fire) begin
         global_irq_reg <= 1'b0;
      end else if (interrupt_return_op_i) begin
         global_irq_reg <= 1'b1;
      end else if (wr_fire && reg_idx == `IDX_STATUS_WORD) begin
         global_irq_reg <= wr_byte[`BIT_GLOBAL_IRQ];
      end
   end

   // pending requests in priority order, each gated by its enable and the global flag
   always_comb begin
      pending    = '0;
      pending[0] = global_irq_reg & general_interrupt_mask_reg[`BIT_PIN_ZERO_EN]
                 & (ext0_level ? ext0_low : ext_flags_reg[`BIT_PIN_ZERO_EN]);
      pending[1] = global_irq_reg & general_interrupt_mask_reg[`BIT_PIN_ONE_EN]
                 & (ext1_level ? ext1_low : ext_flags_reg[`BIT_PIN_ONE_EN]);
      pending[2] = global_irq_reg & timer_interrupt_mask_reg[7] & timer_interrupt_flags_reg[7];
      pending[3] = global_irq_reg & timer_interrupt_mask_reg[6] & timer_interrupt_flags_reg[6];
      pending[4] = global_irq_reg & timer_interrupt_mask_reg[5] & timer_interrupt_flags_reg[5];
      pending[5] = global_irq_reg & timer_interrupt_mask_reg[4] & timer_interrupt_flags_reg[4];
      pending[6] = global_irq_reg & timer_interrupt_mask_reg[3] & timer_interrupt_flags_reg[3];
      pending[7] = global_irq_reg & timer_interrupt_mask_reg[2] & timer_interrupt_flags_reg[2];
      pending[8] = global_irq_reg & timer_interrupt_mask_reg[0] & timer_interrupt_flags_reg[0];
   end

   // scan from the top so the lowest pending index wins
   always_comb begin
      best_idx = 4'd0;
      for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
         if (pending[i]) begin
            best_idx = 4'(i);
         end
      end
   end

   assign any_pending = |pending;

   // request and vector are registered; vector word address is two per source
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_req_o    <= 1'b0;
         irq_vector_o <= 8'h00;
         irq_idx_reg  <= 4'h0;
      end else begin
         irq_req_o    <= any_pending & ~take_fire;
         irq_idx_reg  <= best_idx;
         irq_vector_o <= {3'h0, best_idx, 1'b0} + 8'h02;
      end
   end

   // sleep: armed bit gates entry, any pending request wakes the core
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sleep_o      <= 1'b0;
         sleep_mode_o <= SLEEP_IDLE;
      end else begin
         sleep_mode_o <= sleep_mode_t'(mcu_control_reg[5:4]);
         if (any_pending) begin
            sleep_o <= 1'b0;
         end else if (sleep_op_i && mcu_control_reg[`BIT_SLEEP_ARM]) begin
            sleep_o <= 1'b1;
         end
      end
   end

   // read mux; undefined reserved bits are returned as zero
   always_comb begin
      rd_byte = 8'h00;
      if (reg_idx == `IDX_MCU_CONTROL) begin
         rd_byte = mcu_control_reg;
      end else if (reg_idx == `IDX_TIMER_FLAGS) begin
         rd_byte = timer_interrupt_flags_reg;
      end else if (reg_idx == `IDX_TIMER_MASK) begin
         rd_byte = timer_interrupt_mask_reg;
      end else if (reg_idx == `IDX_EXT_FLAGS) begin
         rd_byte = ext_flags_reg;
      end else if (reg_idx == `IDX_GENERAL_MASK) begin
         rd_byte = general_interrupt_mask_reg;
      end else if (reg_idx == `IDX_STATUS_WORD) begin
         rd_byte = {global_irq_reg, 7'h00};
      end
   end

   // one wait state: ack one cycle after the strobe, dropped the cycle after
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req && !wb_ack_o) begin
            wb_dat_o <= {24'h000000, rd_byte};
         end
      end
   end

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   AST_T2OVF_REQ: assert property (irq_req_o && irq_vector_o == 8'h08 |->
      $past(timer_interrupt_flags_reg[6] && timer_interrupt_mask_reg[6] && global_irq_reg))
      else $error("timer-2 overflow request without cause");
   AST_T0OVF_REQ: assert property (irq_req_o && irq_vector_o == 8'h12 |->
      $past(timer_interrupt_flags_reg[0] && timer_interrupt_mask_reg[0] && !(|pending[7:0])))
      else $error("timer-0 overflow request without cause or over higher priority");
   AST_CAPTURE_SET: assert property (capture_evt_i |=> timer_interrupt_flags_reg[5])
      else $error("capture flag not set after capture");
   AST_T2CMP_SET: assert property (t2_match && !t2_match_prev_reg |=> timer_interrupt_flags_reg[7])
      else $error("compare flag not set on match");
   AST_T1_REVERSE: assert property (t1_updown_mode_i && t1_reverse_i |=> timer_interrupt_flags_reg[2])
      else $error("timer-1 overflow flag not set on reversal");
   AST_TAKE_CLEAR: assert property (take_fire && irq_idx_reg == 4'd8 && !t0_overflow_evt_i
      |=> !timer_interrupt_flags_reg[0] && !global_irq_reg)
      else $error("taken flag or global flag not cleared");
   AST_RETURN_SET: assert property (interrupt_return_op_i && !take_fire |=> global_irq_reg)
      else $error("global flag not set on interrupt return");
   AST_MASK_BIT1: assert property (timer_interrupt_mask_reg[1] == 1'b0 && timer_interrupt_flags_reg[1] == 1'b0)
      else $error("reserved bit 1 not zero");
   AST_LEVEL_NOFLAG: assert property (ext0_level |=> !ext_flags_reg[`BIT_PIN_ZERO_EN])
      else $error("external flag set in level mode");
   AST_LEVEL_HOLD: assert property (ext0_level && ext0_low && global_irq_reg
      && general_interrupt_mask_reg[`BIT_PIN_ZERO_EN] && !take_fire |=> irq_req_o && irq_vector_o == 8'h02)
      else $error("level request not presented");
   AST_SLEEP_UNARMED: assert property (sleep_op_i && !mcu_control_reg[`BIT_SLEEP_ARM] && !sleep_o |=> !sleep_o)
      else $error("sleep entered without arm bit");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");

   COV_TAKE: cover property (irq_req_o ##1 take_fire);
   COV_LEVEL: cover property (ext0_level && pending[0]);
   COV_SLEEP_WAKE: cover property (sleep_o ##[1:20] !sleep_o);
   COV_W1C: cover property (wr_fire && reg_idx == `IDX_TIMER_FLAGS && timer_interrupt_flags_reg != 8'h00);

endmodule : timer_pin_irq_ctrl

// >>> sim/core_model.sv
`timescale 1ns/100ps
module core_model (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       arst_n_i,
   // bench controls: take enable and answer delay
   input  wire logic       en_i,
   input  wire logic [3:0] delay_i,
   // request side of the block
   input  wire logic       irq_req_i,
   input  wire logic [7:0] irq_vector_i,
   output logic            take_o,
   output logic            ret_o,
   output logic [7:0]      last_vec_o
);
   logic [3:0] wait_reg;
   logic [2:0] run_reg;

   // wait, take the presented vector, run a short handler, then return
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_reg   <= 4'h0;
         run_reg    <= 3'h0;
         take_o     <= 1'b0;
         ret_o      <= 1'b0;
         last_vec_o <= 8'h00;
      end else begin
         take_o <= 1'b0;
         ret_o  <= 1'b0;
         if (run_reg != 3'h0) begin
            run_reg <= run_reg + 3'h1;
            ret_o   <= (run_reg == 3'h7);
         end else if (en_i && irq_req_i) begin
            wait_reg <= wait_reg + 4'h1;
            // a delay of zero answers at once, larger ones play a slow core
            if (wait_reg == delay_i) begin
               take_o     <= 1'b1;
               last_vec_o <= irq_vector_i;
               run_reg    <= 3'h1;
               wait_reg   <= 4'h0;
            end
         end else begin
            wait_reg <= 4'h0;
         end
      end
   end
endmodule : core_model

// >>> sim/tb.sv
`timescale 1ns/100ps
`include "irq_ctrl_map.svh"
module tb;
   import irq_ctrl_pkg::*;
   `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("ERROR %s exp %h got %h", nm, e, g); end end
   logic        clk, rst_n, cyc, stb, we, m2, m1, p0, p1, take, ret, sl_op, en, ack, req, slp;
   logic [3:0]  sel, dly;
   logic [7:0]  adr, cmp, vec, pvec, rd;
   logic [9:0]  ev;
   logic [31:0] dw, dr;
   sleep_mode_t smode;
   int          err_total, n_tests, cyc_cnt;
   int          bits[7] = '{7, 6, 5, 4, 3, 2, 0};

   timer_pin_irq_ctrl timer_pin_irq_ctrl_inst (
      .sys_clk_i(clk), .arst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .t2_count_i(ev[7] ? cmp : ~cmp), .t2_compare_value_i(cmp), .t2_overflow_evt_i(ev[6]),
      .t2_updown_mode_i(m2), .t2_reverse_i(ev[8]), .capture_evt_i(ev[5]), .t1_compare_a_evt_i(ev[4]),
      .t1_compare_b_evt_i(ev[3]), .t1_overflow_evt_i(ev[2]), .t1_updown_mode_i(m1), .t1_reverse_i(ev[9]),
      .t0_overflow_evt_i(ev[0]), .ext_irq_pin_zero_i(p0), .ext_irq_pin_one_i(p1), .irq_take_i(take),
      .interrupt_return_op_i(ret), .sleep_op_i(sl_op), .irq_req_o(req), .irq_vector_o(vec),
      .sleep_o(slp), .sleep_mode_o(smode));

   core_model core_model_inst (
      .sys_clk_i(clk), .arst_n_i(rst_n), .en_i(en), .delay_i(dly), .irq_req_i(req),
      .irq_vector_i(vec), .take_o(take), .ret_o(ret), .last_vec_o(pvec));

   // free running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard: the whole run needs fewer than a thousand cycles
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         err_total++;
         close_out();
      end
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // one classic cycle, held until ack is seen at a rising edge
   task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d, input logic [3:0] s);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      sel <= s;
      adr <= {i, 2'b00};
      dw  <= {24'h000000, d};
      // no local limit: a slave that never answers is caught by the hang guard
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = dr[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic rchk(input string nm, input logic [5:0] i, input logic [7:0] e);
      wb(1'b0, i, 8'h00, 4'hf);
      `CHK(nm, e, rd)
   endtask : rchk

   task automatic fire(input logic [9:0] e);
      ev <= e;
      @(posedge clk);
      ev <= 10'h000;
      tick(3);
   endtask : fire

   task automatic sleep_pulse;
      sl_op <= 1'b1;
      @(posedge clk);
      sl_op <= 1'b0;
      tick(2);
   endtask : sleep_pulse

   function automatic logic [7:0] vec_of(input int b);
      return (b == 0) ? 8'h12 : 8'(6 + 2 * (7 - b));
   endfunction : vec_of

   initial begin
      logic [7:0] fl;
      {rst_n, cyc, stb, we, m2, m1, sl_op, en} = 8'h00;
      {p0, p1, sel, dly, adr, cmp, ev, dw} = {2'b11, 66'h0};
      {err_total, n_tests, cyc_cnt} = '0;
      void'($urandom(89));
      tick(8);
      rst_n <= 1'b1;
      tick(2);
      rchk("mcu_control", `IDX_MCU_CONTROL, 8'h00);
      rchk("flags", `IDX_TIMER_FLAGS, 8'h00);
      wb(1'b1, `IDX_TIMER_MASK, 8'hff, 4'he);
      rchk("mask_sel", `IDX_TIMER_MASK, 8'h00);
      wb(1'b1, `IDX_TIMER_MASK, 8'hff, 4'h1);
      rchk("mask_bit1", `IDX_TIMER_MASK, 8'hfd);
      wb(1'b1, `IDX_MCU_CONTROL, 8'hff, 4'h1);
      rchk("mcu_bit7", `IDX_MCU_CONTROL, 8'h7f);
      rchk("unmapped", 6'h10, 8'h00);
      wb(1'b1, `IDX_TIMER_MASK, 8'h00, 4'h1);
      $display("test registers done");
      // each timer source: held while masked, requested, cleared by write and by take
      foreach (bits[k]) begin
         cmp <= 8'($urandom);
         fire(10'h001 << bits[k]);
         rchk("flag_set", `IDX_TIMER_FLAGS, 8'h01 << bits[k]);
         `CHK("masked_req", 1'b0, req)
         wb(1'b1, `IDX_TIMER_MASK, 8'h01 << bits[k], 4'h1);
         wb(1'b1, `IDX_STATUS_WORD, 8'h80, 4'h1);
         tick(2);
         `CHK("req", 1'b1, req)
         `CHK("vector", vec_of(bits[k]), vec)
         wb(1'b1, `IDX_TIMER_FLAGS, 8'h01 << bits[k], 4'h1);
         rchk("w1c", `IDX_TIMER_FLAGS, 8'h00);
         `CHK("req_gone", 1'b0, req)
         en  <= 1'b1;
         dly <= 4'($urandom);
         fire(10'h001 << bits[k]);
         tick(30);
         `CHK("taken_vec", vec_of(bits[k]), pvec)
         rchk("take_clear", `IDX_TIMER_FLAGS, 8'h00);
         rchk("global_back", `IDX_STATUS_WORD, 8'h80);
         en <= 1'b0;
         wb(1'b1, `IDX_STATUS_WORD, 8'h00, 4'h1);
      end
      $display("test timer sources done");
      repeat (4) begin
         {m2, m1} <= 2'($urandom);
         fire(10'h300);
         rchk("reverse", `IDX_TIMER_FLAGS, {1'b0, m2, 3'b000, m1, 2'b00});
         wb(1'b1, `IDX_TIMER_FLAGS, 8'hff, 4'h1);
      end
      // all timer sources pending together are served lowest vector first
      wb(1'b1, `IDX_TIMER_MASK, 8'hfd, 4'h1);
      fire(10'h0fd);
      wb(1'b1, `IDX_STATUS_WORD, 8'h80, 4'h1);
      foreach (bits[k]) begin
         tick(2);
         `CHK("priority", vec_of(bits[k]), vec)
         wb(1'b1, `IDX_TIMER_FLAGS, 8'h01 << bits[k], 4'h1);
      end
      wb(1'b1, `IDX_TIMER_MASK, 8'h00, 4'h1);
      $display("test reverse and priority done");
      wb(1'b1, `IDX_GENERAL_MASK, 8'hc0, 4'h1);
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 4; m++) begin
            wb(1'b1, `IDX_MCU_CONTROL, 8'(m << (2 * p)), 4'h1);
            wb(1'b1, `IDX_EXT_FLAGS, 8'hc0, 4'h1);
            {p1, p0} <= p ? 2'b01 : 2'b10;
            tick(6);
            fl = (m == 1 || m == 2) ? 8'h40 << p : 8'h00;
            rchk("ext_low", `IDX_EXT_FLAGS, fl);
            `CHK("ext_req", (fl != 8'h00 || m == 0), req)
            // the vector only carries meaning while a request stands
            if (fl != 8'h00 || m == 0) `CHK("ext_vec", 8'(2 + 2 * p), vec)
            wb(1'b1, `IDX_EXT_FLAGS, 8'hc0, 4'h1);
            {p1, p0} <= 2'b11;
            tick(6);
            fl = (m == 1 || m == 3) ? 8'h40 << p : 8'h00;
            rchk("ext_high", `IDX_EXT_FLAGS, fl);
            `CHK("ext_req_hi", (fl != 8'h00), req)
         end
      end
      wb(1'b1, `IDX_GENERAL_MASK, 8'h00, 4'h1);
      wb(1'b1, `IDX_MCU_CONTROL, 8'h00, 4'h1);
      wb(1'b1, `IDX_EXT_FLAGS, 8'hc0, 4'h1);
      p1 <= 1'b0;
      tick(6);
      `CHK("ext_unmasked", 1'b0, req)
      p1 <= 1'b1;
      wb(1'b1, `IDX_STATUS_WORD, 8'h00, 4'h1);
      $display("test external pins done");
      wb(1'b1, `IDX_MCU_CONTROL, 8'h3a, 4'h1);
      sleep_pulse();
      `CHK("sleep_unarmed", 1'b0, slp)
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, `IDX_MCU_CONTROL, {2'b01, 2'(m), 4'ha}, 4'h1);
         sleep_pulse();
         `CHK("sleep_armed", 1'b1, slp)
         `CHK("sleep_mode", sleep_mode_t'(m), smode)
      end
      // an enabled request wakes the core
      wb(1'b1, `IDX_TIMER_MASK, 8'h01, 4'h1);
      wb(1'b1, `IDX_STATUS_WORD, 8'h80, 4'h1);
      fire(10'h001);
      `CHK("wake", 1'b0, slp)
      $display("test sleep done");
      close_out();
   end
endmodule : tb
